/* File: fpr_pkg.sv */
// Constants for the flash protection register block
package fpr_pkg;
    localparam logic [7:0] OP_LOCK = 8'h36;
    localparam logic [7:0] OP_LOCK4 = 8'hE1;
    localparam logic [7:0] OP_UNLOCK = 8'h39;
    localparam logic [7:0] OP_UNLOCK4 = 8'hE2;
    localparam logic [7:0] OP_GLOCK = 8'h7E;
    localparam logic [7:0] OP_GUNLOCK = 8'h98;
    localparam logic [7:0] OP_LKRD = 8'h3D;
    localparam logic [7:0] OP_LKRD4 = 8'hE0;
    localparam logic [7:0] OP_KEYRD = 8'hE7;
    localparam logic [7:0] OP_KEYPG = 8'hE8;
    localparam logic [7:0] OP_STRD = 8'hA7;
    localparam logic [7:0] OP_STLOCK = 8'hA6;
    localparam logic [7:0] OP_SETP = 8'hFB;
    localparam logic [7:0] OP_SETP4 = 8'hE3;
    localparam logic [63:0] KEY_RESET = 64'hFFFF_FFFF_FFFF_FFFF;
    localparam logic [31:0] PTR_RESET = 32'hFFFF_FFFF;
    localparam logic [7:0] LOCKED_BYTE = 8'h00;
    localparam logic [7:0] UNLOCKED_BYTE = 8'hFF;
    localparam logic [7:0] REFUSED_BYTE = 8'hFF;
    localparam logic [3:0] KEY_BYTES = 4'h8;
    localparam logic [2:0] ADDR3 = 3'h3;
    localparam logic [2:0] ADDR4 = 3'h4;
    localparam int MODE_PERM = 0;
    localparam int MODE_KEY = 2;
    localparam int MODE_BOOT = 4;
    localparam int MODE_R3 = 6;
    localparam int ST_GUARD = 0;
    localparam int ST_R3 = 6;
    localparam int PTR_SECT_LO = 12;
    localparam int PTR_SCOPE = 11;
    localparam int PTR_EN_N = 10;
    localparam int PTR_DIR = 9;
    localparam int PTR_FIELD_LO = 9;
    localparam int PTR_FIELD_HI = 22;
    typedef enum logic [1:0] {ST_OP, ST_ADDR, ST_DATA} fpr_state_e;
endpackage : fpr_pkg

/* File: fpr_protect.sv */
// Protection state registers behind the serial command port
// Notes on behaviour
// [R1] 64-bit key; no read/program once key mode
// [R2] Unprogrammed key reads as all ones
// [R3] Key shadow has no direct host write
// [R4] Lock status byte volatile, host writes ignored
// [R5] Guard bit zero blocks pointer changes
// [R6] Status lock command sets guard bit
// [R7] Bit 6 mirrors region-3 read guard mode
// [R8] Sector/global lock clears lock bit, 00h
// [R9] Sector/global unlock sets lock bit, FFh
// [R10] Lock access byte shows addressed sector bit
// [R11] Boot default bit sets reset lock state
// [R12] Decode lock, unlock, global lock opcodes
// [R13] Decode key read and key program
// [R14] Pointer config keeps value, no volatile copy
// [R15] Pointer sector bits default to ones
// [R16] Scope bit: selected sectors or all
// [R17] Enable bit low enables pointer guard
// [R18] Direction bit: top or bottom growth
// [R19] Decode set-pointer opcodes, 3 and 4 byte
// [R20] Host programs key before key mode
// [R21] Guard bit restored from mode on reset
`timescale 1ns/100ps
module fpr_protect #(
    parameter int NUM_SECT = 2048,
    parameter int SECT_BITS = 11
) (
    input wire logic CLK_SYS,
    input wire logic RST,
    input wire logic SPI_SCK,
    input wire logic SPI_CS_N,
    input wire logic SPI_MOSI,
    input wire logic [15:0] PROT_MODE_WORD,
    input wire logic [SECT_BITS-1:0] SECT_QUERY,
    output logic SPI_MISO,
    output logic SPI_MISO_OE_N,
    output logic [7:0] LOCK_STATUS,
    output logic [31:0] PTR_CFG,
    output logic SECT_UNLOCKED,
    output logic SECT_PTR_PROT,
    output logic R3_READ_GUARDED
);
    function automatic logic [2:0] fpr_alen(input logic [7:0] op);
        case (op)
            fpr_pkg::OP_LOCK, fpr_pkg::OP_UNLOCK: fpr_alen = fpr_pkg::ADDR3;
            fpr_pkg::OP_LKRD, fpr_pkg::OP_SETP: fpr_alen = fpr_pkg::ADDR3;
            fpr_pkg::OP_LOCK4, fpr_pkg::OP_UNLOCK4: fpr_alen = fpr_pkg::ADDR4;
            fpr_pkg::OP_LKRD4, fpr_pkg::OP_SETP4: fpr_alen = fpr_pkg::ADDR4;
            default: fpr_alen = 3'h0;
        endcase
    endfunction : fpr_alen

    function automatic logic fpr_is_rd(input logic [7:0] op);
        fpr_is_rd = (op == fpr_pkg::OP_STRD) || (op == fpr_pkg::OP_KEYRD)
            || (op == fpr_pkg::OP_LKRD) || (op == fpr_pkg::OP_LKRD4);
    endfunction : fpr_is_rd

    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] mosi_s;
    fpr_pkg::fpr_state_e state_reg;
    fpr_pkg::fpr_state_e state_next;
    logic [7:0] op_reg;
    logic [7:0] sh_reg;
    logic [2:0] bit_reg;
    logic [3:0] byte_reg;
    logic [31:0] addr_reg;
    logic [63:0] key_reg;
    logic [63:0] kbuf_reg;
    logic guard_reg;
    logic [NUM_SECT-1:0] sect_reg;
    logic [31:0] ptr_reg;
    logic [7:0] tx_reg;
    logic [7:0] tx_next;

    // Only the second and third stages feed edge logic
    wire sel = ~cs_s[1];
    wire sck_rise = sck_s[1] & ~sck_s[2];
    wire sck_fall = ~sck_s[1] & sck_s[2];
    wire cs_end = cs_s[1] & ~cs_s[2];
    wire byte_done = sel & sck_rise & (bit_reg == 3'h7);
    wire [7:0] rx = {sh_reg[6:0], mosi_s[1]};
    wire [31:0] addr_full = {addr_reg[23:0], rx};
    wire [2:0] alen = fpr_alen(op_reg);
    wire op_done = byte_done & (state_reg == fpr_pkg::ST_OP);
    wire addr_last = byte_done & (state_reg == fpr_pkg::ST_ADDR)
        & ({1'b0, byte_reg[2:0]} + 4'h1 == {1'b0, alen});
    wire key_ok = PROT_MODE_WORD[fpr_pkg::MODE_KEY]; // [R1]
    wire do_glock = op_done & (rx == fpr_pkg::OP_GLOCK); // [R12]
    wire do_gunl = op_done & (rx == fpr_pkg::OP_GUNLOCK);
    wire do_prl = op_done & (rx == fpr_pkg::OP_STLOCK); // [R6]
    wire do_slock = addr_last
        & ((op_reg == fpr_pkg::OP_LOCK) | (op_reg == fpr_pkg::OP_LOCK4)); // [R12]
    wire do_sunl = addr_last
        & ((op_reg == fpr_pkg::OP_UNLOCK) | (op_reg == fpr_pkg::OP_UNLOCK4));
    wire do_ptr = addr_last & guard_reg
        & ((op_reg == fpr_pkg::OP_SETP) | (op_reg == fpr_pkg::OP_SETP4)); // [R19] [R5]
    // Whole key only; a short or long burst leaves the key alone
    wire key_commit = cs_end & (state_reg == fpr_pkg::ST_DATA) & key_ok
        & (op_reg == fpr_pkg::OP_KEYPG) & (byte_reg == fpr_pkg::KEY_BYTES); // [R13] [R1]
    wire [SECT_BITS-1:0] sect_idx = (state_reg == fpr_pkg::ST_ADDR)
        ? addr_full[SECT_BITS+11:12] : addr_reg[SECT_BITS+11:12];
    wire [7:0] rd_op = (state_reg == fpr_pkg::ST_OP) ? rx : op_reg;
    wire [2:0] kidx = (state_reg == fpr_pkg::ST_DATA) ? byte_reg[2:0] + 3'h1 : 3'h0;
    // Reserved bits always read zero; no write path exists
    wire [7:0] status_w = {1'b0, PROT_MODE_WORD[fpr_pkg::MODE_R3], 5'h00, guard_reg}; // [R4] [R7]
    wire [SECT_BITS-1:0] ptr_sect = ptr_reg[SECT_BITS+11:12];
    wire ptr_hit = ptr_reg[fpr_pkg::PTR_DIR] ? (SECT_QUERY <= ptr_sect)
        : (SECT_QUERY >= ptr_sect); // [R18]
    wire ptr_prot = ~ptr_reg[fpr_pkg::PTR_EN_N]
        & (ptr_reg[fpr_pkg::PTR_SCOPE] | ptr_hit); // [R16] [R17]

    always_comb begin
        state_next = state_reg;
        if (op_done) begin
            state_next = (fpr_alen(rx) != 3'h0) ? fpr_pkg::ST_ADDR : fpr_pkg::ST_DATA;
        end else if (addr_last) begin
            state_next = fpr_pkg::ST_DATA;
        end
    end

    always_comb begin
        case (rd_op)
            fpr_pkg::OP_STRD: tx_next = status_w;
            fpr_pkg::OP_KEYRD: tx_next = key_ok ? key_reg[8*kidx +: 8]
                : fpr_pkg::REFUSED_BYTE; // [R13] [R1]
            fpr_pkg::OP_LKRD, fpr_pkg::OP_LKRD4: tx_next = sect_reg[sect_idx]
                ? fpr_pkg::UNLOCKED_BYTE : fpr_pkg::LOCKED_BYTE; // [R10]
            default: tx_next = fpr_pkg::REFUSED_BYTE;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sck_s <= 3'h0;
            cs_s <= 3'h7;
            mosi_s <= 2'h0;
        end else begin
            sck_s <= {sck_s[1:0], SPI_SCK};
            cs_s <= {cs_s[1:0], SPI_CS_N};
            mosi_s <= {mosi_s[0], SPI_MOSI};
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST || !sel) begin
            state_reg <= fpr_pkg::ST_OP;
            bit_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            if (sck_rise) begin
                bit_reg <= bit_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sh_reg <= 8'h00;
        end else if (sel && sck_rise) begin
            sh_reg <= rx;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            op_reg <= 8'h00;
            byte_reg <= 4'h0;
            addr_reg <= 32'h0000_0000;
        end else if (op_done) begin
            op_reg <= rx;
            byte_reg <= 4'h0;
            addr_reg <= 32'h0000_0000;
        end else if (byte_done && state_reg == fpr_pkg::ST_ADDR) begin
            addr_reg <= addr_full;
            byte_reg <= addr_last ? 4'h0 : byte_reg + 4'h1;
        end else if (byte_done && byte_reg != 4'hF) begin
            byte_reg <= byte_reg + 4'h1;
        end
    end

    // Key bits only go from one to zero, as in one-time storage
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            key_reg <= fpr_pkg::KEY_RESET; // [R2]
            kbuf_reg <= fpr_pkg::KEY_RESET;
        end else begin
            if (byte_done && state_reg == fpr_pkg::ST_DATA) begin
                kbuf_reg <= {rx, kbuf_reg[63:8]};
            end
            if (key_commit) begin
                key_reg <= key_reg & kbuf_reg; // [R3]
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            guard_reg <= PROT_MODE_WORD[fpr_pkg::MODE_KEY]
                & PROT_MODE_WORD[fpr_pkg::MODE_PERM]; // [R21] [R5]
        end else if (do_prl) begin
            guard_reg <= 1'b1; // [R6]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sect_reg <= {NUM_SECT{~PROT_MODE_WORD[fpr_pkg::MODE_BOOT]}}; // [R11]
        end else if (do_glock) begin
            sect_reg <= '0; // [R8]
        end else if (do_gunl) begin
            sect_reg <= '1; // [R9]
        end else if (do_slock) begin
            sect_reg[sect_idx] <= 1'b0; // [R8]
        end else if (do_sunl) begin
            sect_reg[sect_idx] <= 1'b1; // [R9]
        end
    end

    // Reset stands in for first power-up; the value is kept otherwise
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ptr_reg <= fpr_pkg::PTR_RESET; // [R15] [R14]
        end else if (do_ptr) begin
            ptr_reg[fpr_pkg::PTR_FIELD_HI:fpr_pkg::PTR_FIELD_LO]
                <= addr_full[fpr_pkg::PTR_FIELD_HI:fpr_pkg::PTR_FIELD_LO]; // [R14]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            tx_reg <= fpr_pkg::REFUSED_BYTE;
            SPI_MISO <= 1'b1;
            SPI_MISO_OE_N <= 1'b1;
        end else begin
            if (byte_done) begin
                tx_reg <= tx_next;
            end
            if (sel && sck_fall) begin
                SPI_MISO <= tx_reg[3'h7 - bit_reg];
            end
            SPI_MISO_OE_N <= ~(sel && state_reg == fpr_pkg::ST_DATA && fpr_is_rd(op_reg));
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            LOCK_STATUS <= 8'h00;
            PTR_CFG <= fpr_pkg::PTR_RESET;
            SECT_UNLOCKED <= 1'b0;
            SECT_PTR_PROT <= 1'b0;
            R3_READ_GUARDED <= 1'b0;
        end else begin
            LOCK_STATUS <= status_w;
            PTR_CFG <= ptr_reg;
            SECT_UNLOCKED <= sect_reg[SECT_QUERY];
            SECT_PTR_PROT <= ptr_prot;
            R3_READ_GUARDED <= ~PROT_MODE_WORD[fpr_pkg::MODE_R3] & ~guard_reg; // [R7]
        end
    end

    AST_KEY_REFUSE: assert property (@(posedge CLK_SYS) disable iff (RST) // [R1]
        !key_ok |=> $stable(key_reg)) else $error("key changed in key mode");
    AST_KEY_INIT: assert property (@(posedge CLK_SYS) // [R2]
        RST |=> key_reg == fpr_pkg::KEY_RESET) else $error("key not all ones");
    AST_KEY_OTP: assert property (@(posedge CLK_SYS) disable iff (RST) // [R3]
        !key_commit |=> $stable(key_reg)) else $error("key written outside program");
    AST_GUARD_SET: assert property (@(posedge CLK_SYS) disable iff (RST) // [R6]
        do_prl |=> guard_reg ##1 LOCK_STATUS[0]) else $error("lock command missed");
    AST_PTR_BLOCK: assert property (@(posedge CLK_SYS) disable iff (RST) // [R5]
        !guard_reg |=> $stable(ptr_reg)) else $error("pointer changed while guarded");
    AST_R3_MIRROR: assert property (@(posedge CLK_SYS) disable iff (RST) // [R7]
        ##1 LOCK_STATUS[6] == $past(PROT_MODE_WORD[6])) else $error("bit 6 mismatch");
    AST_GLOCK: assert property (@(posedge CLK_SYS) disable iff (RST) // [R8]
        do_glock |=> sect_reg == '0) else $error("global lock failed");
    AST_GUNL: assert property (@(posedge CLK_SYS) disable iff (RST) // [R9]
        do_gunl |=> &sect_reg) else $error("global unlock failed");
    AST_BOOT: assert property (@(posedge CLK_SYS) // [R11]
        RST |=> sect_reg == {NUM_SECT{~$past(PROT_MODE_WORD[4])}}) else $error("boot state");
    AST_PTR_RSV: assert property (@(posedge CLK_SYS) disable iff (RST) // [R15]
        ptr_reg[8:0] == 9'h1FF && ptr_reg[31:23] == 9'h1FF) else $error("reserved bits");

    CVR_KEY_PROG: cover property (@(posedge CLK_SYS) disable iff (RST) key_commit);
    CVR_PTR_SET: cover property (@(posedge CLK_SYS) disable iff (RST) do_ptr);
    CVR_SECT_LOCK: cover property (@(posedge CLK_SYS) disable iff (RST) do_slock);
    CVR_KEY_READ: cover property (@(posedge CLK_SYS) disable iff (RST)
        cs_end && op_reg == fpr_pkg::OP_KEYRD);
endmodule : fpr_protect

/* File: fpr_host_model.sv */
// Serial host model that issues protection commands, mode 0
`timescale 1ns/100ps
module fpr_host_model (
    input wire logic clk,
    input wire logic miso,
    output logic sck,
    output logic cs_n,
    output logic mosi
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(negedge clk);
            mosi = b[i];
            repeat (3) @(negedge clk);
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
    endtask : put_byte
    task automatic get_byte(output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            repeat (4) @(negedge clk);
            b[i] = miso;
            mosi = ~mosi;
            sck = 1'b1;
            repeat (4) @(negedge clk);
            sck = 1'b0;
        end
    endtask : get_byte
    // Address goes out most significant byte first
    task automatic command(input logic [7:0] op, input logic [31:0] addr, input int na);
        @(negedge clk);
        cs_n = 1'b0;
        put_byte(op);
        for (int i = na - 1; i >= 0; i--) begin
            put_byte(addr[8*i +: 8]);
        end
    endtask : command
    // Idle data line keeps toggling so a stale bit never looks valid
    task automatic end_frame();
        repeat (4) @(negedge clk);
        cs_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            @(negedge clk);
            mosi = ~mosi;
        end
    endtask : end_frame
endmodule : fpr_host_model

/* File: test_fpr_protect.sv */
// Self-checking bench for the protection register block
`timescale 1ns/100ps
module test_fpr_protect;
    logic CLK_SYS = 1'b0;
    logic RST = 1'b1;
    logic [15:0] mode = 16'hFFFF;
    logic [10:0] query = 11'h000;
    logic sck, cs_n, mosi, miso, oe_n, unl, prot, r3g;
    logic [7:0] status;
    logic [7:0] rd;
    logic [31:0] ptr;
    logic [31:0] seed = 32'h652CE2C1;
    logic [31:0] addr;
    logic [31:0] eptr;
    logic [63:0] key;
    logic guard;
    int err_count = 0;
    int tests_run = 0;
    logic [7:0] ops [6] = '{fpr_pkg::OP_UNLOCK, fpr_pkg::OP_LOCK, fpr_pkg::OP_UNLOCK4,
        fpr_pkg::OP_LOCK4, fpr_pkg::OP_GUNLOCK, fpr_pkg::OP_GLOCK};
    always #10 CLK_SYS = ~CLK_SYS;
    // Released data line shows a moving pattern, not its last bit
    wire logic host_miso = oe_n ? CLK_SYS : miso;
    fpr_protect fpr_protect_inst (.CLK_SYS(CLK_SYS), .RST(RST), .SPI_SCK(sck),
        .SPI_CS_N(cs_n), .SPI_MOSI(mosi), .PROT_MODE_WORD(mode), .SECT_QUERY(query),
        .SPI_MISO(miso), .SPI_MISO_OE_N(oe_n), .LOCK_STATUS(status), .PTR_CFG(ptr),
        .SECT_UNLOCKED(unl), .SECT_PTR_PROT(prot), .R3_READ_GUARDED(r3g));
    fpr_host_model fpr_host_model_inst (.clk(CLK_SYS), .miso(host_miso), .sck(sck),
        .cs_n(cs_n), .mosi(mosi));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic exp_prot(input logic [31:0] p, input logic [10:0] s);
        if (p[10]) return 1'b0;
        if (p[11]) return 1'b1;
        return p[9] ? (s <= p[22:12]) : (s >= p[22:12]);
    endfunction : exp_prot
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish();
        if (err_count == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk_status();
        fpr_host_model_inst.command(fpr_pkg::OP_STRD, 32'h0, 0);
        fpr_host_model_inst.get_byte(rd);
        fpr_host_model_inst.end_frame();
        check(rd, {1'b0, mode[6], 5'h00, guard});
        check(status, {1'b0, mode[6], 5'h00, guard});
        check(r3g, !mode[6] && !guard);
    endtask : chk_status
    // Sets the pointer, then probes a random sector and the pointer's own sector
    task automatic set_ptr(input logic [7:0] op, input int na);
        fpr_host_model_inst.command(op, addr, na);
        fpr_host_model_inst.end_frame();
        if (guard) eptr = {9'h1FF, addr[22:9], 9'h1FF};
        check(ptr, eptr);
        query = seed[10:0];
        repeat (3) @(negedge CLK_SYS);
        check(prot, exp_prot(eptr, query));
        query = eptr[22:12];
        repeat (3) @(negedge CLK_SYS);
        check(prot, exp_prot(eptr, query));
    endtask : set_ptr
    initial begin
        repeat (60000) @(posedge CLK_SYS);
        err_count++;
        tally_and_finish();
    end
    initial begin
        // Key mode only selected on the last passes, after key writes tried
        // Of the permanent and key mode bits, never both are zero in the same pass
        for (int it = 0; it < 4; it++) begin
            seed = lfsr(seed);
            @(negedge CLK_SYS);
            mode = {seed[15:5], it[0] ^ it[1], seed[3], ~it[1], 1'b1, it[0] | it[1]};
            guard = mode[2] & mode[0];
            RST = 1'b1;
            repeat (5) @(negedge CLK_SYS);
            RST = 1'b0;
            repeat (4) @(negedge CLK_SYS);
            eptr = 32'hFFFF_FFFF;
            check(ptr, eptr);
            check(unl, !mode[4]);
            chk_status();
            addr = lfsr(seed);
            set_ptr(fpr_pkg::OP_SETP, 3);
            fpr_host_model_inst.command(fpr_pkg::OP_STLOCK, 32'h0, 0);
            fpr_host_model_inst.end_frame();
            guard = 1'b1;
            chk_status();
            addr = seed & 32'hFFFF_F3FF;
            set_ptr(fpr_pkg::OP_SETP4, 4);
            key = {seed, lfsr(lfsr(seed))};
            fpr_host_model_inst.command(fpr_pkg::OP_KEYRD, 32'h0, 0);
            for (int i = 0; i < 8; i++) begin
                fpr_host_model_inst.get_byte(rd);
                check(rd, 8'hFF);
            end
            fpr_host_model_inst.end_frame();
            fpr_host_model_inst.command(fpr_pkg::OP_KEYPG, 32'h0, 0);
            for (int i = 0; i < 8; i++) fpr_host_model_inst.put_byte(key[8*i +: 8]);
            fpr_host_model_inst.end_frame();
            fpr_host_model_inst.command(fpr_pkg::OP_KEYRD, 32'h0, 0);
            for (int i = 0; i < 8; i++) begin
                fpr_host_model_inst.get_byte(rd);
                check(rd, mode[2] ? key[8*i +: 8] : 8'hFF);
            end
            fpr_host_model_inst.end_frame();
            for (int i = 0; i < 6; i++) begin
                seed = lfsr(seed);
                query = seed[22:12];
                fpr_host_model_inst.command(ops[i], seed, i > 3 ? 0 : (i < 2 ? 3 : 4));
                fpr_host_model_inst.end_frame();
                check(unl, i % 2 == 0);
                // Both lock read forms, so the 4-byte decode is exercised too
                fpr_host_model_inst.command(i < 3 ? fpr_pkg::OP_LKRD : fpr_pkg::OP_LKRD4, seed,
                    i < 3 ? 3 : 4);
                fpr_host_model_inst.get_byte(rd);
                fpr_host_model_inst.end_frame();
                check(rd, i % 2 == 0 ? 8'hFF : 8'h00);
            end
        end
        tally_and_finish();
    end
endmodule : test_fpr_protect
